// ### src/ctw_dev.sv
// Transceiver mode, wake and fault control inside the system chip.
// Function
// - Wake holds mode code and receive low
// - Re-arm by leaving then re-entering wake
// - Stop or fail-safe entry re-arms wake
// - Host sets wake or off before sleep
// - Re-arm needs no wake flag clear
// - Host enables supply before normal mode
// - Stop/normal wake: interrupt, flag, receive low
// - Stop wake never moves to normal
// - Stop wake enables watchdog when configured
// - Sleep wake goes restart then normal
// - Sleep wake gives no interrupt, sets flag
// - Restart/fail-safe wake gives restart, interrupt high
// - Transmit dominant timeout drops driver, sets fail
// - Transmit recovers when dominant removed
// - Long bus dominant sets fail flag
// - Supply monitored only in listed modes
// - Supply low sets flag, drops driver
// - Supply recovery restores normal automatically
// - Wake pattern is dom, rec, dom windows
// - Off after reset, ignores bus wake
// - Fail-safe entry forces wake-capable mode
//
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module ctw_dev
  import ctw_pkg::*;
#(
  parameter int CNT_W    = 16,
  parameter int WAKE_MIN = CTW_WAKE_MIN_CYC,
  parameter int WAKE_MAX = CTW_WAKE_MAX_CYC,
  parameter int TXD_TO   = CTW_TXD_TO_CYC,
  parameter int BUS_TO   = CTW_BUS_TO_CYC
) (
  input  wire logic CLK_I,
  input  wire logic RST_I,
  input  wire logic CE_I,
  ctw_if.dev        LNK,
  input  wire logic BUS_DOM_I,
  input  wire logic SUPPLY_LOW_I,
  output logic      BUS_DRIVE_O,
  output logic      TX_STAGE_EN_O
);
  // Detector states for the dominant, recessive, dominant wake pattern.
  typedef enum logic [2:0] {
    DET_IDLE, DET_DOM1, DET_REC, DET_DOM2, DET_LONG
  } ctw_det_t;

  // Saturating counter step; used by every timer here.
  function automatic logic [CNT_W-1:0] inc(input logic [CNT_W-1:0] c);
    inc = (&c) ? c : c + {{(CNT_W-1){1'b0}}, 1'b1};
  endfunction : inc

  // True when a phase length lies strictly inside the wake filter window.
  function automatic logic in_win(input logic [CNT_W-1:0] c);
    in_win = (c > CNT_W'(WAKE_MIN)) && (c < CNT_W'(WAKE_MAX));
  endfunction : in_win

  localparam logic [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  logic                 bus_m, bus_s;       // Bus level synchroniser.
  logic                 uvl_m, uvl_s;       // Supply-low synchroniser.
  ctw_det_t             det, next_det;      // Pattern detector state.
  logic [CNT_W-1:0]     dcnt, next_dcnt;    // Phase length counter.
  logic                 wake_det;           // Pattern seen this cycle.
  logic [1:0]           mode, next_mode;    // Transceiver mode field.
  ctw_chip_t            chip, next_chip;    // Chip mode.
  logic                 armed, next_armed;  // Wake capability armed.
  logic                 hold, next_hold;    // Receive held low by wake.
  logic                 from_slp, next_from_slp; // Restart came from sleep.
  logic                 intp, next_intp;    // Interrupt pending.
  logic                 wden, next_wden;    // Watchdog enabled.
  logic                 wdwake, next_wdwake;// Watchdog on bus wake.
  logic [CTW_FLG_W-1:0] flags, next_flags;  // Sticky status flags.
  logic                 tout, next_tout;    // Transmit timeout active.
  logic                 uv, next_uv;        // Supply low active.
  logic [CNT_W-1:0]     tcnt, next_tcnt;    // Transmit dominant timer.
  logic [CNT_W-1:0]     bcnt, next_bcnt;    // Bus dominant timer.
  logic                 rx_active;          // Normal or receive-only.
  logic                 drv_ok;             // Driver stage may transmit.

  // Bus and supply pins come from outside; two flops before any use.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      bus_m <= 1'b0;
      bus_s <= 1'b0;
      uvl_m <= 1'b0;
      uvl_s <= 1'b0;
    end else if (CE_I) begin
      bus_m <= BUS_DOM_I;
      bus_s <= bus_m;
      uvl_m <= SUPPLY_LOW_I;
      uvl_s <= uvl_m;
    end
  end

  // Wake pattern detector; a phase outside the window restarts the search.
  always_comb begin
    next_det  = det;
    next_dcnt = inc(dcnt);
    wake_det  = 1'b0;
    case (det)
      DET_IDLE: begin
        next_dcnt = ONE;
        if (bus_s) next_det = DET_DOM1;
      end
      DET_DOM1, DET_REC, DET_DOM2: begin
        if (dcnt >= CNT_W'(WAKE_MAX)) begin
          // Too long: wait for a recessive bus level before restarting.
          next_det = DET_LONG;
        end else if (bus_s != (det != DET_REC)) begin
          next_dcnt = ONE;
          if (!in_win(dcnt)) next_det = bus_s ? DET_DOM1 : DET_IDLE;
          else if (det == DET_DOM1) next_det = DET_REC;
          else if (det == DET_REC) next_det = DET_DOM2;
          else begin
            next_det = DET_IDLE;
            wake_det = 1'b1;
          end
        end
      end
      DET_LONG: begin
        next_dcnt = ONE;
        if (!bus_s) next_det = DET_IDLE;
      end
      default: next_det = DET_IDLE;
    endcase
  end

  // Detector registers.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      det  <= DET_IDLE;
      dcnt <= '0;
    end else if (CE_I) begin
      det  <= next_det;
      dcnt <= next_dcnt;
    end
  end

  assign rx_active = (mode == CTW_XM_NORMAL) || (mode == CTW_XM_RXONLY);
  // The driver is off in receive-only, on timeout and on supply low.
  assign drv_ok    = (mode == CTW_XM_NORMAL) && !tout && !uv;

  // Mode, wake and fault control.
  always_comb begin
    next_mode     = mode;
    next_chip     = chip;
    next_armed    = armed;
    next_hold     = hold;
    next_from_slp = 1'b0;
    next_intp     = intp;
    next_wden     = wden;
    next_wdwake   = wdwake;
    next_flags    = flags;
    next_tout     = tout;
    next_uv       = uv;
    next_tcnt     = '0;
    next_bcnt     = '0;
    // Software clears go first so that hardware sets below win.
    if (LNK.clr_we) begin
      next_flags = flags & ~LNK.clr_bits;
      if (LNK.clr_bits[CTW_FLG_WAKE]) next_intp = 1'b0;
    end
    // Restart after a sleep wake proceeds to normal on its own.
    if (from_slp && chip == CTW_CHIP_RESTART) next_chip = CTW_CHIP_NORMAL;
    if (LNK.cfg_we) begin
      next_wdwake = LNK.cfg_wdwake;
      next_wden   = LNK.cfg_wden;
      next_mode   = LNK.cfg_mode;
      // Any change of mode ends the wake hold.
      if (LNK.cfg_mode != mode) next_hold = 1'b0;
      // A fresh entry into wake-capable re-arms, as do stop and fail-safe below; flag untouched.
      if (LNK.cfg_mode == CTW_XM_WAKE && mode != CTW_XM_WAKE)
        next_armed = 1'b1;
      next_chip = LNK.cfg_chip;
      if (LNK.cfg_chip == CTW_CHIP_STOP || LNK.cfg_chip == CTW_CHIP_FAILSAFE)
        next_armed = 1'b1;
      if (LNK.cfg_chip == CTW_CHIP_FAILSAFE) begin
        next_mode = CTW_XM_WAKE;
        next_hold = 1'b0;
      end
    end
    // A pattern counts only when wake-capable and armed; off ignores it.
    if (wake_det && mode == CTW_XM_WAKE && armed) begin
      next_armed = 1'b0;
      next_hold  = 1'b1;
      next_flags[CTW_FLG_WAKE] = 1'b1;
      case (chip)
        CTW_CHIP_NORMAL, CTW_CHIP_STOP: begin
          // Chip mode stays; a host command in this cycle still counts.
          next_intp = 1'b1;
          if (chip == CTW_CHIP_STOP && wdwake && !wden)
            next_wden = 1'b1;
        end
        CTW_CHIP_SLEEP: begin
          next_chip     = CTW_CHIP_RESTART;
          next_from_slp = 1'b1;
        end
        CTW_CHIP_RESTART, CTW_CHIP_FAILSAFE: begin
          next_chip = CTW_CHIP_RESTART;
        end
        default: next_chip = chip;
      endcase
    end
    // Transmit dominant timeout in normal mode, released by recessive.
    if (mode == CTW_XM_NORMAL && !LNK.txd) begin
      next_tcnt = inc(tcnt);
      if (tcnt >= CNT_W'(TXD_TO)) begin
        next_tout = 1'b1;
        next_flags[CTW_FLG_FAIL] = 1'b1;
      end
    end else begin
      next_tout = 1'b0;
    end
    // Bus clamp detection leaves the configuration alone.
    if (rx_active && bus_s) begin
      next_bcnt = inc(bcnt);
      if (bcnt >= CNT_W'(BUS_TO)) next_flags[CTW_FLG_FAIL] = 1'b1;
    end
    // Supply low is watched only in the listed modes and self-heals.
    if (rx_active && (chip == CTW_CHIP_NORMAL || chip == CTW_CHIP_STOP)) begin
      next_uv = uvl_s;
      if (uvl_s) next_flags[CTW_FLG_UV] = 1'b1;
    end else begin
      next_uv = 1'b0;
    end
  end

  // Control registers; transceiver starts off after reset.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      mode     <= CTW_XM_RESET;
      chip     <= CTW_CHIP_NORMAL;
      armed    <= 1'b1;
      hold     <= 1'b0;
      from_slp <= 1'b0;
      intp     <= 1'b0;
      wden     <= 1'b0;
      wdwake   <= 1'b0;
      flags    <= '0;
      tout     <= 1'b0;
      uv       <= 1'b0;
      tcnt     <= '0;
      bcnt     <= '0;
    end else if (CE_I) begin
      mode     <= next_mode;
      chip     <= next_chip;
      armed    <= next_armed;
      hold     <= next_hold;
      from_slp <= next_from_slp;
      intp     <= next_intp;
      wden     <= next_wden;
      wdwake   <= next_wdwake;
      flags    <= next_flags;
      tout     <= next_tout;
      uv       <= next_uv;
      tcnt     <= next_tcnt;
      bcnt     <= next_bcnt;
    end
  end

  // Receive follows the bus only when receiving and no wake is held.
  assign LNK.rxd        = hold ? 1'b0 : (rx_active ? !bus_s : 1'b1);
  assign LNK.int_n      = !intp;
  assign LNK.stat_mode  = mode;
  assign LNK.stat_chip  = chip;
  assign LNK.stat_flags = flags;
  assign LNK.stat_wden  = wden;
  assign BUS_DRIVE_O    = drv_ok && !LNK.txd;
  assign TX_STAGE_EN_O  = drv_ok;
endmodule : ctw_dev

// ### src/ctw_pkg.sv
// Shared constants, codes and types for the transceiver wake and fault control.
package ctw_pkg;
  // Transceiver mode codes; only the wake-capable code is fixed.
  localparam logic [1:0] CTW_XM_OFF    = 2'h0;
  localparam logic [1:0] CTW_XM_WAKE   = 2'h1;
  localparam logic [1:0] CTW_XM_RXONLY = 2'h2;
  localparam logic [1:0] CTW_XM_NORMAL = 2'h3;
  localparam logic [1:0] CTW_XM_RESET  = CTW_XM_OFF;

  // Chip operating modes.
  typedef enum logic [2:0] {
    CTW_CHIP_NORMAL,
    CTW_CHIP_STOP,
    CTW_CHIP_SLEEP,
    CTW_CHIP_RESTART,
    CTW_CHIP_FAILSAFE
  } ctw_chip_t;

  // Status flag positions inside the three-bit flag vector.
  localparam int CTW_FLG_WAKE = 0;
  localparam int CTW_FLG_FAIL = 1;
  localparam int CTW_FLG_UV   = 2;
  localparam int CTW_FLG_W    = 3;

  // Timing in nanoseconds and the clock period.
  localparam int CTW_CLK_NS        = 4;
  localparam int CTW_WAKE_MIN_NS   = 500;
  localparam int CTW_WAKE_MAX_NS   = 4000;
  localparam int CTW_TXD_TO_NS     = 4000;
  localparam int CTW_BUS_TO_NS     = 4000;
  // Least times round up, longest times round down.
  localparam int CTW_WAKE_MIN_CYC  = (CTW_WAKE_MIN_NS + CTW_CLK_NS - 1)
                                     / CTW_CLK_NS;
  localparam int CTW_WAKE_MAX_CYC  = CTW_WAKE_MAX_NS / CTW_CLK_NS;
  localparam int CTW_TXD_TO_CYC    = (CTW_TXD_TO_NS + CTW_CLK_NS - 1)
                                     / CTW_CLK_NS;
  localparam int CTW_BUS_TO_CYC    = (CTW_BUS_TO_NS + CTW_CLK_NS - 1)
                                     / CTW_CLK_NS;

  // Host register byte offsets.
  localparam logic [3:0] CTW_REG_CTRL   = 4'h0;
  localparam logic [3:0] CTW_REG_STATUS = 4'h4;
  localparam logic [3:0] CTW_REG_CLEAR  = 4'h8;
  // Control register fields.
  localparam int CTW_CTRL_MODE_LO = 0;
  localparam int CTW_CTRL_CHIP_LO = 2;
  localparam int CTW_CTRL_WDWAKE  = 5;
  localparam int CTW_CTRL_WDEN    = 6;
  localparam int CTW_CTRL_SUPPLY  = 7;
  localparam logic [7:0] CTW_CTRL_RESET = 8'h00;
  // Status register fields.
  localparam int CTW_ST_MODE_LO  = 0;
  localparam int CTW_ST_CHIP_LO  = 2;
  localparam int CTW_ST_FLAG_LO  = 5;
  localparam int CTW_ST_WDEN     = 8;
  localparam int CTW_ST_RXD      = 9;
  localparam int CTW_ST_INTN     = 10;
  localparam int CTW_ST_REFUSED  = 11;
  // Clear register: bits 2..0 clear flags, bit 3 clears refused.
  localparam int CTW_CLR_REFUSED = 3;
endpackage : ctw_pkg

// ### src/ctw_if.sv
// Link between the transceiver control device and its host controller.
`timescale 1ns/1ps
interface ctw_if;
  import ctw_pkg::*;
  logic                  txd;          // Transmit data in, low is dominant.
  logic                  rxd;          // Receive data out, low is dominant.
  logic                  int_n;        // Interrupt, active low.
  logic                  cfg_we;       // One-cycle configuration write.
  logic [1:0]            cfg_mode;     // Requested transceiver mode.
  ctw_chip_t             cfg_chip;     // Requested chip mode.
  logic                  cfg_wdwake;   // Watchdog on bus wake.
  logic                  cfg_wden;     // Watchdog enable.
  logic                  clr_we;       // One-cycle flag clear strobe.
  logic [CTW_FLG_W-1:0]  clr_bits;     // Flags to clear.
  logic [1:0]            stat_mode;    // Transceiver mode read back.
  ctw_chip_t             stat_chip;    // Chip mode read back.
  logic [CTW_FLG_W-1:0]  stat_flags;   // Wake, fail, supply-low flags.
  logic                  stat_wden;    // Watchdog enabled.

  modport dev (input txd, cfg_we, cfg_mode, cfg_chip, cfg_wdwake,
               cfg_wden, clr_we, clr_bits,
               output rxd, int_n, stat_mode, stat_chip, stat_flags,
               stat_wden);
  modport host (output txd, cfg_we, cfg_mode, cfg_chip, cfg_wdwake,
                cfg_wden, clr_we, clr_bits,
                input rxd, int_n, stat_mode, stat_chip, stat_flags,
                stat_wden);
endinterface : ctw_if

// ### src/ctw_host.sv
// Host-side controller: Avalon-MM registers driving the device link.
`timescale 1ns/1ps
module ctw_host
  import ctw_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        CE_I,
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  ctw_if.host              LNK,
  input  wire logic        TXD_I,
  output logic             RXD_O,
  output logic             SUPPLY_EN_O
);
  logic [7:0]           ctrl, next_ctrl;       // Control register.
  logic                 refused, next_refused; // Command refused since last clear.
  logic                 ack, next_ack;         // Answer cycle of an access.
  logic [31:0]          rdata, next_rdata;     // Registered read data.
  logic                 we, next_we;           // Configuration strobe.
  logic                 cwe, next_cwe;         // Clear strobe.
  logic [CTW_FLG_W-1:0] cbits, next_cbits;     // Clear bits.
  logic [7:0]           wd;                    // Written control byte.
  logic [1:0]           wmode;                 // Written transceiver mode.
  logic [2:0]           wchip;                 // Written chip mode.
  logic                 bad;                   // Write breaks host duties.
  logic                 wr_ok;                 // Write taken this cycle.

  assign wd    = AVS_WRITEDATA_I[7:0];
  assign wmode = wd[CTW_CTRL_MODE_LO +: 2];
  assign wchip = wd[CTW_CTRL_CHIP_LO +: 3];
  // Sleep needs wake or off, normal needs the supply on, both in the same write.
  assign bad   = (ctw_chip_t'(wchip) == CTW_CHIP_SLEEP &&
                  !(wmode == CTW_XM_WAKE || wmode == CTW_XM_OFF)) ||
                 (wmode == CTW_XM_NORMAL && !wd[CTW_CTRL_SUPPLY]);
  // Each access takes one wait cycle so that read data come from a flop.
  // A write lands only in the answer cycle, when waitrequest is low.
  assign wr_ok = AVS_WRITE_I && ack && AVS_BYTEENABLE_I[0];

  // Bus slave and command strobes.
  always_comb begin
    next_ctrl    = ctrl;
    next_refused = refused;
    next_ack     = (AVS_READ_I || AVS_WRITE_I) && !ack;
    next_rdata   = rdata;
    next_we      = 1'b0;
    next_cwe     = 1'b0;
    next_cbits   = '0;
    if (wr_ok && AVS_ADDRESS_I == CTW_REG_CTRL) begin
      if (bad) begin
        next_refused = 1'b1;
        // Supply switching is still honoured on a refused command.
        next_ctrl[CTW_CTRL_SUPPLY] = wd[CTW_CTRL_SUPPLY];
      end else begin
        // Mode toggles pass through untouched; the device re-arms.
        next_ctrl = wd;
        next_we   = 1'b1;
      end
    end
    if (wr_ok && AVS_ADDRESS_I == CTW_REG_CLEAR) begin
      next_cwe   = 1'b1;
      next_cbits = wd[CTW_FLG_W-1:0];
      if (wd[CTW_CLR_REFUSED]) next_refused = 1'b0;
    end
    if (AVS_READ_I && !ack) begin
      next_rdata = 32'h0000_0000;
      case (AVS_ADDRESS_I)
        CTW_REG_CTRL: next_rdata[7:0] = ctrl;
        CTW_REG_STATUS: begin
          next_rdata[CTW_ST_MODE_LO +: 2] = LNK.stat_mode;
          next_rdata[CTW_ST_CHIP_LO +: 3] = LNK.stat_chip;
          next_rdata[CTW_ST_FLAG_LO +: CTW_FLG_W] = LNK.stat_flags;
          next_rdata[CTW_ST_WDEN]    = LNK.stat_wden;
          next_rdata[CTW_ST_RXD]     = LNK.rxd;
          next_rdata[CTW_ST_INTN]    = LNK.int_n;
          next_rdata[CTW_ST_REFUSED] = refused;
        end
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Host registers.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ctrl    <= CTW_CTRL_RESET;
      refused <= 1'b0;
      ack     <= 1'b0;
      rdata   <= 32'h0000_0000;
      we      <= 1'b0;
      cwe     <= 1'b0;
      cbits   <= '0;
    end else if (CE_I) begin
      ctrl    <= next_ctrl;
      refused <= next_refused;
      ack     <= next_ack;
      rdata   <= next_rdata;
      we      <= next_we;
      cwe     <= next_cwe;
      cbits   <= next_cbits;
    end
  end

  assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !ack;
  assign AVS_READDATA_O    = rdata;
  assign LNK.txd        = TXD_I;
  assign LNK.cfg_we     = we;
  assign LNK.cfg_mode   = ctrl[CTW_CTRL_MODE_LO +: 2];
  assign LNK.cfg_chip   = ctw_chip_t'(ctrl[CTW_CTRL_CHIP_LO +: 3]);
  assign LNK.cfg_wdwake = ctrl[CTW_CTRL_WDWAKE];
  assign LNK.cfg_wden   = ctrl[CTW_CTRL_WDEN];
  assign LNK.clr_we     = cwe;
  assign LNK.clr_bits   = cbits;
  assign RXD_O          = LNK.rxd;
  assign SUPPLY_EN_O    = ctrl[CTW_CTRL_SUPPLY];
endmodule : ctw_host

// ### verification/ctw_assertions.sv
// Concurrent checks on the link between host controller and device.
`timescale 1ns/1ps
module ctw_assertions
  import ctw_pkg::*;
(
  input  wire logic                 CLK_I,
  input  wire logic                 RST_I,
  input  wire logic                 rxd,
  input  wire logic                 int_n,
  input  wire logic                 cfg_we,
  input  wire logic [1:0]           cfg_mode,
  input  ctw_chip_t                 cfg_chip,
  input  wire logic                 cfg_wdwake,
  input  wire logic [1:0]           stat_mode,
  input  ctw_chip_t                 stat_chip,
  input  wire logic [CTW_FLG_W-1:0] stat_flags,
  input  wire logic                 stat_wden
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  wire wk = stat_flags[CTW_FLG_WAKE]; // Bus wake flag.

  AST_CFG_MODE: assert property (cfg_we && cfg_chip != CTW_CHIP_FAILSAFE
    |=> stat_mode == $past(cfg_mode)) else $error("mode not taken");
  AST_FS_WAKE: assert property (cfg_we && cfg_chip == CTW_CHIP_FAILSAFE
    |=> stat_mode == CTW_XM_WAKE) else $error("fail-safe not wake");
  AST_OFF_DEAF: assert property (stat_mode == CTW_XM_OFF && !wk
    && $past(stat_mode) == CTW_XM_OFF |=> !wk) else $error("off woke");
  AST_RXD_HOLD: assert property ($rose(wk) && !cfg_we
    |-> (stat_mode == CTW_XM_WAKE && !rxd) [*2]) else $error("no hold");
  AST_INT_WAKE: assert property ($rose(wk) && stat_chip inside
    {CTW_CHIP_NORMAL, CTW_CHIP_STOP} |-> !int_n) else $error("no int");
  AST_STOP_HOLD: assert property (stat_chip == CTW_CHIP_STOP && !cfg_we
    |=> stat_chip == CTW_CHIP_STOP) else $error("stop left alone");
  AST_WD_WAKE: assert property ($rose(wk) && stat_chip == CTW_CHIP_STOP
    && cfg_wdwake |-> stat_wden) else $error("watchdog not enabled");
  AST_SLEEP: assert property ($past(stat_chip) == CTW_CHIP_SLEEP
    && stat_chip == CTW_CHIP_RESTART |-> $stable(int_n) ##1
    stat_chip == CTW_CHIP_NORMAL) else $error("sleep exit wrong");
  AST_RESTART: assert property ($rose(wk) && $past(stat_chip) inside
    {CTW_CHIP_RESTART, CTW_CHIP_FAILSAFE} |-> stat_chip == CTW_CHIP_RESTART
    && $stable(int_n)) else $error("restart wake wrong");

  // Main scenarios seen at least once.
  C_STOP: cover property ($rose(wk) && stat_chip == CTW_CHIP_STOP);
  C_FAIL: cover property ($rose(stat_flags[CTW_FLG_FAIL]));
  C_UV: cover property ($rose(stat_flags[CTW_FLG_UV]));
endmodule : ctw_assertions

// ### verification/testbench.sv
// Self-checking bench: host controller and device joined by the link.
`timescale 1ns/1ps
module testbench;
  import ctw_pkg::*;
  localparam int WMIN = 4;   // Short wake filter keeps the run brief.
  localparam int WMAX = 20;
  localparam int TOUT = 20;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        waitreq;
  logic        txd = 1'b1;
  logic        rxd_o;
  logic        bus = 1'b0;
  logic        low = 1'b0;
  logic        drive;
  logic        tx_en;
  logic        sup_en;
  logic [31:0] got;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  // Model of the device state as the status word shows it.
  int m_mode, m_chip, m_flags, m_wden, m_wdw, m_rxd, m_intn, m_ref, m_arm;

  ctw_if lnk ();
  ctw_host i_ctw_host (.CLK_I(clk), .RST_I(rst), .CE_I(1'b1),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .LNK(lnk.host),
    .TXD_I(txd), .RXD_O(rxd_o), .SUPPLY_EN_O(sup_en));
  ctw_dev #(.WAKE_MIN(WMIN), .WAKE_MAX(WMAX), .TXD_TO(TOUT), .BUS_TO(TOUT))
    i_ctw_dev (.CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .LNK(lnk.dev),
    .BUS_DOM_I(bus), .SUPPLY_LOW_I(low), .BUS_DRIVE_O(drive),
    .TX_STAGE_EN_O(tx_en));
  ctw_assertions u_chk (.CLK_I(clk), .RST_I(rst), .rxd(lnk.rxd),
    .int_n(lnk.int_n), .cfg_we(lnk.cfg_we), .cfg_mode(lnk.cfg_mode),
    .cfg_chip(lnk.cfg_chip), .cfg_wdwake(lnk.cfg_wdwake),
    .stat_mode(lnk.stat_mode), .stat_chip(lnk.stat_chip),
    .stat_flags(lnk.stat_flags), .stat_wden(lnk.stat_wden));

  always #2 clk = ~clk;

  // A hang counts as a mismatch and closes the run.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  task automatic ck(input string n, input logic [31:0] e, s);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : ck

  // One bus cycle; waitrequest and read data are taken at the rising edge.
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do @(posedge clk); while (waitreq !== 1'b0);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : av

  task automatic status();
    av(1'b0, CTW_REG_STATUS, 32'h0);
    ck("status", m_mode | m_chip << 2 | m_flags << 5 | m_wden << 8 |
       m_rxd << 9 | m_intn << 10 | m_ref << 11, {20'h0, got[11:0]});
    ck("rxd pin", m_rxd, rxd_o);
  endtask : status

  // Control write; the model refuses what the host must not command.
  task automatic ctl(input int md, cp, wdw, wden, sup);
    av(1'b1, CTW_REG_CTRL, 32'(sup << 7 | wden << 6 | wdw << 5 | cp << 2 | md));
    if ((cp == CTW_CHIP_SLEEP && !(md inside {CTW_XM_WAKE, CTW_XM_OFF})) ||
        (md == CTW_XM_NORMAL && sup == 0)) m_ref = 1;
    else begin
      if (cp == CTW_CHIP_FAILSAFE) md = CTW_XM_WAKE;
      if (cp == CTW_CHIP_STOP || cp == CTW_CHIP_FAILSAFE) m_arm = 1;
      if (md == CTW_XM_WAKE && m_mode != CTW_XM_WAKE) m_arm = 1;
      if (md != m_mode || cp == CTW_CHIP_FAILSAFE) m_rxd = 1;
      m_mode = md;
      m_chip = cp;
      m_wdw = wdw;
      m_wden = wden;
    end
    repeat (3) @(posedge clk);
  endtask : ctl

  task automatic clr();
    av(1'b1, CTW_REG_CLEAR, 32'h0000000f);
    m_flags = 0;
    m_ref = 0;
    m_intn = 1;
    repeat (2) @(posedge clk);
  endtask : clr

  // Dominant, recessive, dominant phases of random legal length.
  task automatic wake_pattern();
    @(posedge clk);
    for (int p = 0; p < 3; p++) begin
      bus <= (p != 1);
      repeat (WMIN + 1 + $urandom % (WMAX - WMIN - 1)) @(posedge clk);
    end
    bus <= 1'b0;
    repeat (8) @(posedge clk);
    if (m_mode == CTW_XM_WAKE && m_arm == 1) begin
      m_arm = 0;
      m_flags |= 1;
      m_rxd = 0;
      case (m_chip)
        CTW_CHIP_NORMAL, CTW_CHIP_STOP: begin
          m_intn = 0;
          if (m_chip == CTW_CHIP_STOP && m_wdw == 1) m_wden = 1;
        end
        CTW_CHIP_SLEEP: m_chip = CTW_CHIP_NORMAL;
        default: m_chip = CTW_CHIP_RESTART;
      endcase
    end
  endtask : wake_pattern

  initial begin
    void'($urandom(96));
    {m_mode, m_chip, m_flags, m_wden, m_wdw, m_ref} = '0;
    {m_rxd, m_intn, m_arm} = {32'd1, 32'd1, 32'd1};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    status();
    ck("supply", 32'h0, {31'h0, sup_en});
    av(1'b0, 4'hc, 32'h0);
    ck("unmapped", 32'h0, got);
    wake_pattern(); status();
    ctl(CTW_XM_WAKE, CTW_CHIP_NORMAL, 0, 0, 0);
    wake_pattern(); status();
    clr(); wake_pattern(); status();
    for (int i = 0; i < 2; i++) begin
      ctl(i ? CTW_XM_OFF : CTW_XM_RXONLY, CTW_CHIP_NORMAL, 0, 0, 0);
      ctl(CTW_XM_WAKE, CTW_CHIP_NORMAL, 0, 0, 0);
      wake_pattern(); status();
    end
    clr();
    ctl(CTW_XM_WAKE, CTW_CHIP_STOP, 1, 0, 0);
    wake_pattern(); status();
    clr();
    ctl(CTW_XM_OFF, CTW_CHIP_FAILSAFE, 0, 0, 0); status();
    wake_pattern(); status();
    ctl(CTW_XM_NORMAL, CTW_CHIP_SLEEP, 0, 0, 1); status();
    clr();
    ctl(CTW_XM_OFF, CTW_CHIP_SLEEP, 0, 0, 0);
    ctl(CTW_XM_WAKE, CTW_CHIP_SLEEP, 0, 0, 0);
    wake_pattern(); status();
    clr();
    ctl(CTW_XM_NORMAL, CTW_CHIP_NORMAL, 0, 0, 1);
    ck("supply", 32'h1, {31'h0, sup_en});
    txd <= 1'b0;
    repeat (3) @(posedge clk);
    ck("drive", 32'h1, {31'h0, drive});
    repeat (TOUT + 4) @(posedge clk);
    ck("tx stage", 32'h0, {31'h0, tx_en | drive});
    txd <= 1'b1;
    repeat (3) @(posedge clk);
    ck("tx back", 32'h1, {31'h0, tx_en});
    m_flags = 2;
    status();
    clr();
    bus <= 1'b1;
    repeat (TOUT + 6) @(posedge clk);
    bus <= 1'b0;
    repeat (4) @(posedge clk);
    m_flags = 2;
    status();
    clr();
    low <= 1'b1;
    repeat (6) @(posedge clk);
    ck("uv stage", 32'h0, {31'h0, tx_en});
    m_flags = 4;
    status();
    low <= 1'b0;
    repeat (6) @(posedge clk);
    ck("uv back", 32'h1, {31'h0, tx_en});
    ctl(CTW_XM_NORMAL, CTW_CHIP_RESTART, 0, 0, 1);
    clr();
    low <= 1'b1;
    repeat (6) @(posedge clk);
    status();
    wrap_up();
  end
endmodule : testbench
